// ### src/hbf_pkg.sv
`default_nettype none
package hbf_pkg;
    localparam int          STRAP_W        = 8;
    localparam int          BUS_W          = 16;
    localparam int          UPPER_W        = 5;
    localparam int          MEM_ADDR_W     = 20;
    localparam int          SYNC_STAGES    = 2;
    localparam int          STRAP_DIR_BIT  = 3;
    localparam int          STRAP_MODE_BIT = 2;
    localparam int          STRAP_SEL_BIT  = 3;
    localparam int          SENSE_LINE     = 15;
    localparam int          SENSE_BIT      = 4;
    localparam int          FEAT_OUT_BIT   = 1;
    localparam logic [15:0] PORT_MISC      = 16'h03C2;
    localparam logic [31:0] ADDR_STRAP     = 32'h0000_0000;
    localparam logic [31:0] ADDR_FEATURE   = 32'h0000_0004;
    localparam logic [31:0] ADDR_MISC      = 32'h0000_0008;
    localparam logic [31:0] ADDR_STATUS    = 32'h0000_000C;
    localparam logic [31:0] ADDR_CLKSEL    = 32'h0000_0010;
    localparam logic [7:0]  FEATURE_RST    = 8'h00;
    localparam logic [7:0]  MISC_RST       = 8'h00;
    localparam logic [1:0]  CLKSEL_PIXEL_CLOCK_0   = 2'h0;
    localparam logic [1:0]  CLKSEL_PIXEL_CLOCK_1_OR_SELECT   = 2'h1;
    localparam logic [1:0]  CLKSEL_PIXEL_CLOCK_2_OR_SELECT   = 2'h2;

    typedef enum logic [1:0] {
        HBF_IDLE  = 2'b00,
        HBF_ADDR  = 2'b01,
        HBF_DATA  = 2'b11
    } hbf_cyc_t;

    typedef struct packed {
        logic [BUS_W-1:0]   muxed_addr_data_bus;
        logic [UPPER_W-1:0] upper_address_inputs;
        logic               display_memory_enable;
        logic               ale;
        logic               io_rd_n;
        logic               io_wr_n;
        logic               mem_rd_n;
        logic               mem_wr_n;
        logic               rom_sel;
    } hbf_host_in_t;

    typedef struct packed {
        logic                  mem_req;
        logic                  mem_we;
        logic                  rom_req;
        logic                  io_req;
        logic                  io_we;
        logic [MEM_ADDR_W-1:0] mem_addr;
        logic [15:0]           io_addr;
        logic [7:0]            io_wdata;
    } hbf_host_req_t;
endpackage
`default_nettype wire

// ### src/hbf_sync.sv
`default_nettype none
module hbf_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule
`default_nettype wire

// ### src/hbf_front_end.sv
`default_nettype none
module hbf_front_end (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic [31:0]                   paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [hbf_pkg::STRAP_W-1:0]   memory_data_straps,
    input  wire hbf_pkg::hbf_host_in_t         host_in,
    output hbf_pkg::hbf_host_req_t             host_req,
    output logic [7:0]                         io_rdata,
    output logic                               addr_buffer_enable_n,
    output logic                               addr_buffer_enable_n_oe,
    output logic                               data_buffer_enable_n,
    output logic                               data_buffer_enable_n_oe,
    input  wire logic                          pixel_clock_1_or_select_in,
    output logic                               pixel_clock_1_or_select_out,
    output logic                               pixel_clock_1_or_select_oe,
    input  wire logic                          pixel_clock_2_or_select_in,
    output logic                               pixel_clock_2_or_select_out,
    output logic                               pixel_clock_2_or_select_oe,
    output logic [1:0]                         video_clock_sel
);
    // reset release synchroniser
    logic rst_s1_r;
    logic rst_s2_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // pin synchronisers
    localparam int HW = $bits(hbf_pkg::hbf_host_in_t);
    hbf_pkg::hbf_host_in_t hs;
    logic [hbf_pkg::STRAP_W-1:0] straps_s;
    hbf_sync #(.W(HW)) u_host_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (host_in),
        .q       (hs)
    );
    hbf_sync #(.W(hbf_pkg::STRAP_W)) u_strap_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (memory_data_straps),
        .q       (straps_s)
    );

    // configuration latched once after release
    logic [7:0] strap_config_reg_r;
    logic [7:0] strap_config_reg_nxt;
    logic [7:0] bus_width_config_reg_r;
    logic [7:0] bus_width_config_reg_nxt;
    logic       loaded_r;
    logic       loaded_nxt;
    always_comb begin
        strap_config_reg_nxt     = strap_config_reg_r;
        bus_width_config_reg_nxt = bus_width_config_reg_r;
        loaded_nxt               = loaded_r;
        if (rst_s2_r && !loaded_r) begin
            strap_config_reg_nxt     = straps_s;
            bus_width_config_reg_nxt = straps_s;
            loaded_nxt               = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_config_reg_r     <= 8'h00;
            bus_width_config_reg_r <= 8'h00;
            loaded_r               <= 1'b0;
        end else begin
            strap_config_reg_r     <= strap_config_reg_nxt;
            bus_width_config_reg_r <= bus_width_config_reg_nxt;
            loaded_r               <= loaded_nxt;
        end
    end

    logic pins_out;
    logic channel_mode;
    assign pins_out     = strap_config_reg_r[hbf_pkg::STRAP_DIR_BIT];
    assign channel_mode = strap_config_reg_r[hbf_pkg::STRAP_MODE_BIT];

    // host cycle sequencer
    hbf_pkg::hbf_cyc_t cyc_r;
    hbf_pkg::hbf_cyc_t cyc_nxt;
    logic [hbf_pkg::BUS_W-1:0] addr_lat_r;
    logic [hbf_pkg::BUS_W-1:0] addr_lat_nxt;
    logic [hbf_pkg::UPPER_W-1:0] up_lat_r;
    logic [hbf_pkg::UPPER_W-1:0] up_lat_nxt;
    logic io_rd_d_r;
    logic io_wr_d_r;
    logic mem_rd_d_r;
    logic mem_wr_d_r;
    logic io_rd_e;
    logic io_wr_e;
    logic mem_rd_e;
    logic mem_wr_e;
    assign io_rd_e  = !hs.io_rd_n && io_rd_d_r;
    assign io_wr_e  = !hs.io_wr_n && io_wr_d_r;
    assign mem_rd_e = !hs.mem_rd_n && mem_rd_d_r;
    assign mem_wr_e = !hs.mem_wr_n && mem_wr_d_r;

    always_comb begin
        cyc_nxt      = cyc_r;
        addr_lat_nxt = addr_lat_r;
        up_lat_nxt   = up_lat_r;
        case (cyc_r)
            hbf_pkg::HBF_IDLE: begin
                if (loaded_r && hs.ale) begin
                    addr_lat_nxt = hs.muxed_addr_data_bus;
                    up_lat_nxt   = hs.upper_address_inputs;
                    cyc_nxt      = hbf_pkg::HBF_ADDR;
                end
            end
            hbf_pkg::HBF_ADDR: begin
                if (io_rd_e || io_wr_e || mem_rd_e || mem_wr_e) begin
                    cyc_nxt = hbf_pkg::HBF_DATA;
                end else if (hs.ale) begin
                    addr_lat_nxt = hs.muxed_addr_data_bus;
                    up_lat_nxt   = hs.upper_address_inputs;
                end
            end
            hbf_pkg::HBF_DATA: begin
                if (hs.io_rd_n && hs.io_wr_n && hs.mem_rd_n && hs.mem_wr_n) begin
                    cyc_nxt = hbf_pkg::HBF_IDLE;
                end
            end
            default: cyc_nxt = hbf_pkg::HBF_IDLE;
        endcase
    end

    // request decode
    hbf_pkg::hbf_host_req_t req_nxt;
    hbf_pkg::hbf_host_req_t req_r;
    logic io_ok;
    logic mem_ok;
    logic rom_ok;
    logic in_addr;
    assign in_addr = (cyc_r == hbf_pkg::HBF_ADDR);
    assign io_ok   = in_addr && (!channel_mode || hs.display_memory_enable);
    assign mem_ok  = in_addr && hs.display_memory_enable && !hs.rom_sel;
    assign rom_ok  = in_addr && hs.rom_sel && !channel_mode;
    always_comb begin
        req_nxt          = '0;
        req_nxt.io_addr  = addr_lat_r;
        req_nxt.mem_addr = {up_lat_r, addr_lat_r[hbf_pkg::MEM_ADDR_W-hbf_pkg::UPPER_W-1:0]};
        req_nxt.io_wdata = hs.muxed_addr_data_bus[7:0];
        req_nxt.io_req   = io_ok && (io_rd_e || io_wr_e);
        req_nxt.io_we    = io_ok && io_wr_e;
        req_nxt.mem_req  = mem_ok && (mem_rd_e || mem_wr_e);
        req_nxt.mem_we   = mem_ok && mem_wr_e;
        req_nxt.rom_req  = (rom_ok || (channel_mode && in_addr && hs.rom_sel)) && mem_rd_e;
    end

    // monitor sense, misc output and pulse
    logic [7:0] misc_r;
    logic [7:0] misc_nxt;
    logic       sense_r;
    logic       sense_nxt;
    logic       wr_pulse_n_r;
    logic       wr_pulse_n_nxt;
    logic [7:0] feature_r;
    logic [7:0] feature_nxt;
    logic       apb_wr;
    assign apb_wr = psel && penable && pwrite && pstrb[0];
    always_comb begin
        misc_nxt       = misc_r;
        sense_nxt      = sense_r;
        feature_nxt    = feature_r;
        wr_pulse_n_nxt = 1'b1;
        if (apb_wr && paddr == hbf_pkg::ADDR_MISC) begin
            misc_nxt = pwdata[7:0];
        end
        if (apb_wr && paddr == hbf_pkg::ADDR_FEATURE) begin
            feature_nxt = pwdata[7:0];
        end
        if (req_nxt.io_req) begin
            sense_nxt = hs.muxed_addr_data_bus[hbf_pkg::SENSE_LINE];
        end
        if (req_nxt.io_we && addr_lat_r == hbf_pkg::PORT_MISC) begin
            misc_nxt       = hs.muxed_addr_data_bus[7:0];
            wr_pulse_n_nxt = 1'b0;
        end
        if (cyc_r == hbf_pkg::HBF_DATA && !hs.io_wr_n && !wr_pulse_n_r) begin
            wr_pulse_n_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_r        <= hbf_pkg::HBF_IDLE;
            addr_lat_r   <= '0;
            up_lat_r     <= '0;
            io_rd_d_r    <= 1'b1;
            io_wr_d_r    <= 1'b1;
            mem_rd_d_r   <= 1'b1;
            mem_wr_d_r   <= 1'b1;
            req_r        <= '0;
            misc_r       <= hbf_pkg::MISC_RST;
            feature_r    <= hbf_pkg::FEATURE_RST;
            sense_r      <= 1'b0;
            wr_pulse_n_r <= 1'b1;
        end else begin
            cyc_r        <= cyc_nxt;
            addr_lat_r   <= addr_lat_nxt;
            up_lat_r     <= up_lat_nxt;
            io_rd_d_r    <= hs.io_rd_n;
            io_wr_d_r    <= hs.io_wr_n;
            mem_rd_d_r   <= hs.mem_rd_n;
            mem_wr_d_r   <= hs.mem_wr_n;
            req_r        <= req_nxt;
            misc_r       <= misc_nxt;
            feature_r    <= feature_nxt;
            sense_r      <= sense_nxt;
            wr_pulse_n_r <= wr_pulse_n_nxt;
        end
    end

    assign host_req = req_r;
    assign io_rdata = {misc_r[7:5], sense_r, misc_r[3:0]};

    // video clock select
    always_comb begin
        case (misc_r[3:2])
            2'b00:   video_clock_sel = hbf_pkg::CLKSEL_PIXEL_CLOCK_0;
            2'b01:   video_clock_sel = pins_out ? hbf_pkg::CLKSEL_PIXEL_CLOCK_0 : hbf_pkg::CLKSEL_PIXEL_CLOCK_1_OR_SELECT;
            2'b10:   video_clock_sel = pins_out ? hbf_pkg::CLKSEL_PIXEL_CLOCK_0 : hbf_pkg::CLKSEL_PIXEL_CLOCK_2_OR_SELECT;
            default: video_clock_sel = hbf_pkg::CLKSEL_PIXEL_CLOCK_0;
        endcase
    end

    assign pixel_clock_1_or_select_oe  = pins_out;
    assign pixel_clock_1_or_select_out = wr_pulse_n_r;
    assign pixel_clock_2_or_select_oe  = pins_out;
    assign pixel_clock_2_or_select_out = strap_config_reg_r[hbf_pkg::STRAP_SEL_BIT] &&
                                         feature_r[hbf_pkg::FEAT_OUT_BIT];

    // buffer enables float until configured
    assign addr_buffer_enable_n_oe = loaded_r;
    assign data_buffer_enable_n_oe = loaded_r;
    assign addr_buffer_enable_n    = !(cyc_r == hbf_pkg::HBF_ADDR && (io_ok || mem_ok || rom_ok));
    assign data_buffer_enable_n    = !(cyc_r == hbf_pkg::HBF_DATA);

    // apb slave
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux  = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            hbf_pkg::ADDR_STRAP:   rd_mux = {16'h0000, bus_width_config_reg_r, strap_config_reg_r};
            hbf_pkg::ADDR_FEATURE: rd_mux = {24'h00_0000, feature_r};
            hbf_pkg::ADDR_MISC:    rd_mux = {24'h00_0000, misc_r};
            hbf_pkg::ADDR_STATUS:  rd_mux = {24'h00_0000, io_rdata};
            hbf_pkg::ADDR_CLKSEL:  rd_mux = {28'h000_0000, pixel_clock_2_or_select_in,
                                             pixel_clock_1_or_select_in, video_clock_sel};
            default:               pslverr = psel && penable;
        endcase
    end
    logic [31:0] prdata_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else begin
            prdata_r <= (psel && !penable) ? rd_mux : prdata_r;
        end
    end
    assign prdata = prdata_r;
    assign pready = 1'b1;
endmodule
`default_nettype wire

// ### verif/hbf_host_model.sv
`default_nettype none
module hbf_host_model (
    input  wire logic                  pclk,
    output var  hbf_pkg::hbf_host_in_t host_in
);
    timeunit 1ns;
    timeprecision 1ps;
    hbf_pkg::hbf_host_in_t h;
    // idle bus: strobes high, latch low
    initial begin
        h = '0;
        {h.io_rd_n, h.io_wr_n, h.mem_rd_n, h.mem_wr_n} = 4'hF;
        host_in = h;
    end
    // k: 0 io read, 1 io write, 2 mem read, 3 mem write, 4 rom read
    task automatic cycle(input int k, input logic [15:0] a, input logic [4:0] up,
                         input logic [7:0] d, input logic s, input logic en);
        @(posedge pclk);
        h.muxed_addr_data_bus   = (k < 2) ? {s, a[14:0]} : a;
        h.upper_address_inputs  = up;
        h.display_memory_enable = en;
        h.rom_sel               = (k == 4);
        h.ale                   = 1'b1;
        host_in <= h;
        repeat (3) @(posedge pclk);
        h.ale                 = 1'b0;
        h.muxed_addr_data_bus = {s, ~a[14:8], d};
        h.io_rd_n             = (k != 0);
        h.io_wr_n             = (k != 1);
        h.mem_rd_n            = !(k == 2 || k == 4);
        h.mem_wr_n            = (k != 3);
        host_in <= h;
        repeat (8) @(posedge pclk);
        // strobes go high and the released bus shows the inverse of its last value
        {h.io_rd_n, h.io_wr_n, h.mem_rd_n, h.mem_wr_n} = 4'hF;
        h.muxed_addr_data_bus   = ~h.muxed_addr_data_bus;
        h.display_memory_enable = 1'b0;
        h.rom_sel               = 1'b0;
        host_in <= h;
        repeat (6) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ### verif/hbf_front_end_props.sv
`default_nettype none
module hbf_front_end_props (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [31:0]            paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pready,
    input  wire logic                   pslverr,
    input  wire hbf_pkg::hbf_host_req_t host_req,
    input  wire logic                   addr_buffer_enable_n_oe,
    input  wire logic                   data_buffer_enable_n_oe,
    input  wire logic                   pixel_clock_1_or_select_out,
    input  wire logic                   pixel_clock_1_or_select_oe,
    input  wire logic                   pixel_clock_2_or_select_oe,
    input  wire logic [1:0]             video_clock_sel
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_clk1_low;
        $fell(pixel_clock_1_or_select_out) && pixel_clock_1_or_select_oe;
    endsequence
    buf_float_a: assert property (disable iff (1'b0) !presetn |->
        !addr_buffer_enable_n_oe && !data_buffer_enable_n_oe) else $error("buffer enable driven in reset");
    pin_dir_a: assert property (pixel_clock_1_or_select_oe == pixel_clock_2_or_select_oe)
        else $error("clock pins differ in direction");
    sel_fallback_a: assert property (pixel_clock_1_or_select_oe |-> video_clock_sel == 2'h0)
        else $error("clock select not pixel clock 0");
    zero_wait_a: assert property (s_acc |-> pready) else $error("pready low in access");
    err_place_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    unmapped_a: assert property (s_acc and paddr > 32'h0000_0010 |-> pslverr) else $error("no pslverr");
    io_pulse_a: assert property (host_req.io_req |=> !host_req.io_req)
        else $error("io request longer than one cycle");
    mem_pulse_a: assert property (host_req.mem_req |=> !host_req.mem_req)
        else $error("memory request longer than one cycle");
    req_excl_a: assert property (!(host_req.io_req && host_req.mem_req))
        else $error("io and memory request together");
    clk1_pulse_a: assert property (s_clk1_low |-> ##[1:40] pixel_clock_1_or_select_out)
        else $error("pixel clock 1 pulse stuck low");
endmodule
bind hbf_front_end hbf_front_end_props hbf_front_end_props_inst (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .host_req(host_req), .addr_buffer_enable_n_oe(addr_buffer_enable_n_oe),
    .data_buffer_enable_n_oe(data_buffer_enable_n_oe),
    .pixel_clock_1_or_select_out(pixel_clock_1_or_select_out),
    .pixel_clock_1_or_select_oe(pixel_clock_1_or_select_oe),
    .pixel_clock_2_or_select_oe(pixel_clock_2_or_select_oe), .video_clock_sel(video_clock_sel));
`default_nettype wire

// ### verif/hbf_front_end_tb.sv
`default_nettype none
module hbf_front_end_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext1, ext2;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] memory_data_straps, io_rdata;
    hbf_pkg::hbf_host_in_t host_in;
    hbf_pkg::hbf_host_req_t host_req;
    logic a_n, a_oe, d_n, d_oe, c1_in, c1_out, c1_oe, c2_in, c2_out, c2_oe;
    logic [1:0] video_clock_sel, gated;
    logic io_seen, mem_seen, rom_seen, low_seen;
    logic [24:0] io_cap;
    logic [19:0] mem_cap;
    int fails, checked, cyc;
    hbf_front_end hbf_front_end_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .memory_data_straps(memory_data_straps),
        .host_in(host_in), .host_req(host_req), .io_rdata(io_rdata), .addr_buffer_enable_n(a_n),
        .addr_buffer_enable_n_oe(a_oe), .data_buffer_enable_n(d_n), .data_buffer_enable_n_oe(d_oe),
        .pixel_clock_1_or_select_in(c1_in), .pixel_clock_1_or_select_out(c1_out),
        .pixel_clock_1_or_select_oe(c1_oe), .pixel_clock_2_or_select_in(c2_in),
        .pixel_clock_2_or_select_out(c2_out), .pixel_clock_2_or_select_oe(c2_oe),
        .video_clock_sel(video_clock_sel));
    hbf_host_model hbf_host_model_inst (.pclk(pclk), .host_in(host_in));
    // pin level from whoever drives it
    assign c1_in = c1_oe ? c1_out : ext1;
    assign c2_in = c2_oe ? c2_out : ext2;
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        ext1 <= ~ext1;
        ext2 <= 1'($urandom());
        cyc <= cyc + 1;
        if (host_req.io_req) begin
            io_seen <= 1'b1;
            io_cap <= {host_req.io_we, host_req.io_addr, host_req.io_wdata};
        end
        if (host_req.mem_req) begin
            mem_seen <= 1'b1;
            mem_cap <= host_req.mem_addr;
        end
        if (host_req.rom_req) rom_seen <= 1'b1;
        if (host_req.io_req || host_req.mem_req) chk("buf_enables", 2'b10, {a_n, d_n});
        if (c1_oe === 1'b1 && c1_out === 1'b0 && presetn) low_seen <= 1'b1;
        if (cyc == 8000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            $display("unexpected %s expected %h seen %h", n, x, g);
            fails++;
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic host(input int k, input logic [15:0] a, input logic [4:0] up, input logic [7:0] d,
                        input logic s, input logic en);
        {io_seen, mem_seen, rom_seen, low_seen} = 4'h0;
        hbf_host_model_inst.cycle(k, a, up, d, s, en);
    endtask
    task automatic round(input logic r);
        logic [7:0] st, f, d;
        logic [31:0] rd;
        logic e;
        logic [15:0] a;
        logic [4:0] up;
        st = 8'($urandom());
        st[2] = r;
        st[3] = r;
        f = 8'($urandom());
        d = 8'($urandom());
        a = 16'($urandom());
        up = 5'($urandom());
        memory_data_straps <= st;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("buffer_oe", 0, {a_oe, d_oe});
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, hbf_pkg::ADDR_STRAP, 0, rd, e);
        chk("straps", {st, st}, rd[15:0]);
        chk("pin_dir", {r, r}, {c1_oe, c2_oe});
        apb(1'b1, hbf_pkg::ADDR_FEATURE, {24'h0, f}, rd, e);
        @(posedge pclk);
        chk("clk2_out", r & f[1], c2_out);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, hbf_pkg::ADDR_MISC, 32'(i << 2), rd, e);
            @(posedge pclk);
            chk("clock_sel", r ? 0 : i, video_clock_sel);
        end
        apb(1'b0, hbf_pkg::ADDR_CLKSEL, 0, rd, e);
        chk("clksel_reg", r ? 0 : 2, rd[1:0]);
        for (int i = 0; i < 2; i++) begin
            host(0, hbf_pkg::PORT_MISC, 5'h1F, 8'h00, i[0], 1'b1);
            chk("sense", i, io_rdata[4]);
        end
        host(1, hbf_pkg::PORT_MISC, up, d, 1'b0, 1'b1);
        chk("io_write", {1'b1, hbf_pkg::PORT_MISC, d}, io_cap);
        chk("clk1_pulse", r, low_seen);
        host(1, 16'h03C4, up, d, 1'b0, 1'b1);
        chk("clk1_quiet", 0, low_seen);
        host(3, a, up, d, 1'b0, 1'b1);
        chk("mem_addr", {1'b1, up, a[14:0]}, {mem_seen, mem_cap});
        host(2, a, up, d, 1'b0, 1'b0);
        chk("mem_gated", 0, mem_seen);
        host(4, a, up, d, 1'b0, 1'b0);
        chk("rom_free", 1, rom_seen);
        host(1, 16'h03C4, up, d, 1'b0, 1'b0);
        gated[r] = !io_seen;
        apb(1'b0, 32'h0000_0020, 0, rd, e);
        chk("unmapped", 1, e);
        $display("round %0d ended, mismatches %0d", r, fails);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, ext1, ext2} = '0;
        {paddr, pwdata, pstrb, memory_data_straps, fails, checked, cyc} = '0;
        void'($urandom(84));
        round(1'b0);
        round(1'b1);
        chk("mode_gate", 2'b10, gated);
        wrap_up();
    end
endmodule
`default_nettype wire
